//--- rtl/dwsp_pkg.sv
// shared constants of the dual wiper serial shift port: frame layout,
// wiper codes and link timing; used by both ends and the interface users
`default_nettype none

package dwsp_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int          FRAME_BITS     = 17;
  localparam int          WIPER_BITS     = 8;
  localparam int          STACK_POS      = 0;
  localparam int          POT_ONE_MSB    = 1;
  localparam int          POT_ONE_LSB    = 8;
  localparam int          POT_ZERO_MSB   = 9;
  localparam int          POT_ZERO_LSB   = 16;
  localparam logic [16:0] SHIFT_RESET    = 17'h00000;
  localparam logic [7:0]  WIPER_RESET    = 8'h00;

  // ----------------------------------------------------------------
  // wiper codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  WIPER_HIGH_END = 8'hff;
  localparam logic [7:0]  WIPER_LOW_END  = 8'h00;

  // ----------------------------------------------------------------
  // timing, ref_clk at 20 MHz
  // ----------------------------------------------------------------
  localparam int REF_CLK_NS       = 50;
  localparam int SCLK_HALF_NS     = 200;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + REF_CLK_NS - 1) / REF_CLK_NS;
  localparam int SYNC_STAGES      = 2;

endpackage

`default_nettype wire

//--- rtl/dwsp_if.sv
// three-wire link between the controller and the wiper device
// the data line models the feedback resistor: the controller wins while
// it drives, otherwise the cascade output is seen on the line
`timescale 1ns/1ps
`default_nettype none

interface dwsp_if;
  logic serialEnable;
  logic serialClock;
  logic hostData;
  logic hostDataOe;
  logic cascadeOut;
  logic dataLine;

  assign dataLine = hostDataOe ? hostData : cascadeOut;

  modport device (
    input  serialEnable,
    input  serialClock,
    input  dataLine,
    output cascadeOut
  );

  modport host (
    output serialEnable,
    output serialClock,
    output hostData,
    output hostDataOe,
    input  cascadeOut
  );
endinterface

`default_nettype wire

//--- rtl/dwsp_sync.sv
// two flip-flop synchroniser for a group of independent levels
// assumes each bit is a slow level from another clock domain or a pin
`timescale 1ns/1ps
`default_nettype none

module dwsp_sync
  import dwsp_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta;

  // refuse an empty group at elaboration, not at run time
  if (WIDTH < 1) begin : gBadWidth
    $error("dwsp_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta    <= '0;
      syncOut <= '0;
    end else begin
      meta    <= asyncIn;
      syncOut <= meta;
    end
  end

endmodule

`default_nettype wire

//--- rtl/dwsp_device.sv
// wiper device end: 17-bit serial shift register, wiper latches on the
// falling enable, stacked wiper selector and cascade output
// assumes the link pins are asynchronous to ref_clk and slow enough that
// each clock level lasts at least two ref_clk periods
`timescale 1ns/1ps
`default_nettype none

module dwsp_device
  import dwsp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  dwsp_if.device           link,
  output logic [7:0]       wiperZero,
  output logic [7:0]       wiperOne,
  output logic             stackSel,
  output logic [7:0]       stackedWiper,
  output logic             highEndTerminalZero,
  output logic             lowEndTerminalZero,
  output logic             highEndTerminalOne,
  output logic             lowEndTerminalOne,
  output logic             wiperLoad
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [FRAME_BITS-1:0] shiftReg;
    logic [7:0]            wiperZero;
    logic [7:0]            wiperOne;
    logic                  stackSel;
    logic [7:0]            stackedWiper;
    logic                  highZero;
    logic                  lowZero;
    logic                  highOne;
    logic                  lowOne;
    logic                  cascadeOut;
    logic                  enablePrev;
    logic                  clockPrev;
    logic                  wiperLoad;
  } dwsp_dev_s;

  localparam dwsp_dev_s DEV_RESET = '{
    shiftReg:     SHIFT_RESET,
    wiperZero:    WIPER_RESET,
    wiperOne:     WIPER_RESET,
    stackSel:     1'b0,
    stackedWiper: WIPER_RESET,
    highZero:     1'b0,
    lowZero:      1'b1,
    highOne:      1'b0,
    lowOne:       1'b1,
    cascadeOut:   1'b0,
    enablePrev:   1'b0,
    clockPrev:    1'b0,
    wiperLoad:    1'b0
  };

  dwsp_dev_s state_reg;
  dwsp_dev_s state_next;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  // pulls a wiper value whose MSB sits at msbPos, LSB at msbPos+7
  function automatic logic [7:0] wiperField(input logic [FRAME_BITS-1:0] frame,
                                            input int                    msbPos);
    logic [7:0] value;
    value = '0;
    for (int i = 0; i < WIPER_BITS; i++) begin
      value[WIPER_BITS-1-i] = frame[msbPos+i];
    end
    return value;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pinsSync;
  logic       enableSync;
  logic       clockSync;
  logic       dataSync;

  // clock and data share the same delay, so data is still valid at the edge
  dwsp_sync #(
    .WIDTH (3)
  ) pinSync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .asyncIn ({link.serialEnable, link.serialClock, link.dataLine}),
    .syncOut (pinsSync)
  );

  assign enableSync = pinsSync[2];
  assign clockSync  = pinsSync[1];
  assign dataSync   = pinsSync[0];

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  logic clockRise;
  logic enableFall;

  assign clockRise  = enableSync && clockSync && !state_reg.clockPrev;
  assign enableFall = state_reg.enablePrev && !enableSync;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [FRAME_BITS-1:0] loadFrame;
    loadFrame  = state_reg.shiftReg;
    state_next = state_reg;

    state_next.enablePrev = enableSync;
    state_next.clockPrev  = clockSync;
    state_next.wiperLoad  = 1'b0;

    // input enters the last position, FRAME_BITS-1
    // shift toward position 0 so the first bit sent ends at the stack flag
    if (clockRise) begin
      state_next.shiftReg = {dataSync, state_reg.shiftReg[FRAME_BITS-1:1]};
    end

    state_next.cascadeOut = state_next.shiftReg[STACK_POS];

    if (enableFall) begin
      state_next.wiperOne  = wiperField(loadFrame, POT_ONE_MSB);
      state_next.wiperZero = wiperField(loadFrame, POT_ZERO_MSB);
      state_next.stackSel  = loadFrame[STACK_POS];
      state_next.wiperLoad = 1'b1;
    end

    state_next.stackedWiper = state_next.stackSel ? state_next.wiperOne
                                                  : state_next.wiperZero;

    state_next.highZero = (state_next.wiperZero == WIPER_HIGH_END);
    state_next.lowZero  = (state_next.wiperZero == WIPER_LOW_END);
    state_next.highOne  = (state_next.wiperOne == WIPER_HIGH_END);
    state_next.lowOne   = (state_next.wiperOne == WIPER_LOW_END);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // the shift register is never cleared by the enable; only rst clears it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= DEV_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.cascadeOut     = state_reg.cascadeOut;
  assign wiperZero           = state_reg.wiperZero;
  assign wiperOne            = state_reg.wiperOne;
  assign stackSel            = state_reg.stackSel;
  assign stackedWiper        = state_reg.stackedWiper;
  assign highEndTerminalZero = state_reg.highZero;
  assign lowEndTerminalZero  = state_reg.lowZero;
  assign highEndTerminalOne  = state_reg.highOne;
  assign lowEndTerminalOne   = state_reg.lowOne;
  assign wiperLoad           = state_reg.wiperLoad;

endmodule

`default_nettype wire

//--- rtl/dwsp_host.sv
// controller end: frames of 17 bits per chained device, written MSB first,
// with optional circular read-back through the cascade feedback
// assumes the cascade input comes from the last device of the chain
`timescale 1ns/1ps
`default_nettype none

module dwsp_host
  import dwsp_pkg::*;
#(
  parameter int DEVICES = 1
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  dwsp_if.host                             link,
  input  wire logic                        start,
  input  wire logic                        readBack,
  input  wire logic [FRAME_BITS*DEVICES-1:0] txWord,
  output logic                             busy,
  output logic                             done,
  output logic [FRAME_BITS*DEVICES-1:0]    rxWord
);

  localparam int TOTAL = FRAME_BITS * DEVICES;
  localparam int CW    = $clog2(TOTAL + 1);
  localparam int DW    = $clog2(SCLK_HALF_CYCLES + 1);

  // an empty chain leaves the shift slices without bits
  if (DEVICES < 1) begin : gBadDevices
    $error("dwsp_host: DEVICES must be at least 1");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    IDLE  = 5'b00001,
    LEAD  = 5'b00010,
    LOW   = 5'b00100,
    HIGH  = 5'b01000,
    TRAIL = 5'b10000
  } dwsp_host_e;

  typedef struct packed {
    dwsp_host_e       phase;
    logic [DW-1:0]    divCount;
    logic [CW-1:0]    bitsLeft;
    logic [TOTAL-1:0] txShift;
    logic [TOTAL-1:0] rxShift;
    logic             reading;
    logic             enable;
    logic             sclk;
    logic             dataOut;
    logic             dataOe;
    logic             done;
    logic             busy;
  } dwsp_host_s;

  dwsp_host_s state_reg;
  dwsp_host_s state_next;

  logic cascadeSync;

  dwsp_sync #(
    .WIDTH (1)
  ) cascadeSyncer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .asyncIn (link.cascadeOut),
    .syncOut (cascadeSync)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic tick;
  assign tick = (state_reg.divCount == DW'(SCLK_HALF_CYCLES - 1));

  always_comb begin
    state_next          = state_reg;
    state_next.done     = 1'b0;
    state_next.divCount = tick ? '0 : state_reg.divCount + DW'(1);
    unique case (state_reg.phase)
      IDLE: begin
        state_next.divCount = '0;
        if (start) begin
          state_next.phase    = LEAD;
          state_next.enable   = 1'b1;
          state_next.reading  = readBack;
          state_next.dataOe   = !readBack;
          state_next.txShift  = txWord;
          state_next.bitsLeft = CW'(TOTAL);
        end
      end
      LEAD: begin
        if (tick) begin
          state_next.phase   = LOW;
          state_next.dataOut = state_reg.txShift[TOTAL-1];
        end
      end
      LOW: begin
        if (tick) begin
          state_next.phase    = HIGH;
          state_next.sclk     = 1'b1;
          state_next.rxShift  = {state_reg.rxShift[TOTAL-2:0], cascadeSync};
          state_next.txShift  = {state_reg.txShift[TOTAL-2:0], 1'b0};
          state_next.bitsLeft = state_reg.bitsLeft - CW'(1);
        end
      end
      HIGH: begin
        if (tick) begin
          state_next.sclk    = 1'b0;
          state_next.dataOut = state_reg.txShift[TOTAL-1];
          state_next.phase   = (state_reg.bitsLeft == '0) ? TRAIL : LOW;
        end
      end
      TRAIL: begin
        if (tick) begin
          state_next.phase  = IDLE;
          state_next.enable = 1'b0;
          state_next.dataOe = 1'b0;
          state_next.done   = 1'b1;
        end
      end
    endcase
    // registered so the port needs no decode after the flop
    state_next.busy = (state_next.phase != IDLE);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '{phase: IDLE, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.serialEnable = state_reg.enable;
  assign link.serialClock  = state_reg.sclk;
  assign link.hostData     = state_reg.dataOut;
  assign link.hostDataOe   = state_reg.dataOe;
  assign busy              = state_reg.busy;
  assign done              = state_reg.done;
  assign rxWord            = state_reg.rxShift;

endmodule

`default_nettype wire

//--- tb/dwsp_checker.sv
// assertions on the three-wire link and the wiper outputs of one device
// assumes it sits beside the interface that joins the host and the device
`timescale 1ns/1ps
`default_nettype none

module dwsp_checker (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       serialEnable,
  input wire logic       serialClock,
  input wire logic       cascadeOut,
  input wire logic [7:0] wiperZero,
  input wire logic [7:0] wiperOne,
  input wire logic       stackSel,
  input wire logic [7:0] stackedWiper,
  input wire logic       highEndTerminalZero,
  input wire logic       lowEndTerminalZero,
  input wire logic       highEndTerminalOne,
  input wire logic       lowEndTerminalOne,
  input wire logic       wiperLoad
);
  logic [3:0] sinceRise;
  logic [3:0] sinceFall;
  logic       clkSeen;
  logic       enSeen;

  // ----------------------------------------------------------------
  // edge age counters, saturating so idle links never wrap
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sinceRise <= 4'hf;
      sinceFall <= 4'hf;
      clkSeen   <= 1'b0;
      enSeen    <= 1'b0;
    end else begin
      clkSeen   <= serialClock;
      enSeen    <= serialEnable;
      sinceRise <= (serialEnable && serialClock && !clkSeen) ? 4'h0 :
                   (sinceRise == 4'hf) ? sinceRise : sinceRise + 4'h1;
      sinceFall <= (enSeen && !serialEnable) ? 4'h0 :
                   (sinceFall == 4'hf) ? sinceFall : sinceFall + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_frozen;
    (!serialEnable) [*5] |-> $stable(cascadeOut);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("cascade moved while disabled");

  property p_shift_cause;
    $changed(cascadeOut) |-> sinceRise <= 4'h3;
  endproperty
  a_shift_cause: assert property (p_shift_cause)
    else $error("cascade moved without a clock");

  property p_load_soon;
    $fell(serialEnable) |-> ##[1:5] wiperLoad;
  endproperty
  a_load_soon: assert property (p_load_soon)
    else $error("no load after enable fall");

  property p_load_cause;
    wiperLoad |-> sinceFall <= 4'h3;
  endproperty
  a_load_cause: assert property (p_load_cause)
    else $error("load without enable fall");

  property p_wiper_hold;
    ($changed(wiperZero) || $changed(wiperOne) || $changed(stackSel)) |-> wiperLoad;
  endproperty
  a_wiper_hold: assert property (p_wiper_hold)
    else $error("wiper moved outside a load");

  property p_stacked;
    stackedWiper == (stackSel ? wiperOne : wiperZero);
  endproperty
  a_stacked: assert property (p_stacked)
    else $error("stacked wiper wrong");

  property p_ends_zero;
    highEndTerminalZero == (wiperZero == 8'hff) && lowEndTerminalZero == (wiperZero == 8'h00);
  endproperty
  a_ends_zero: assert property (p_ends_zero)
    else $error("terminal flags of wiper zero wrong");

  property p_ends_one;
    highEndTerminalOne == (wiperOne == 8'hff) && lowEndTerminalOne == (wiperOne == 8'h00);
  endproperty
  a_ends_one: assert property (p_ends_one)
    else $error("terminal flags of wiper one wrong");

  property p_lead;
    $rose(serialEnable) |-> (!serialClock) [*4];
  endproperty
  a_lead: assert property (p_lead)
    else $error("clock too soon after enable");

  property p_clk_framed;
    $rose(serialClock) |-> serialEnable;
  endproperty
  a_clk_framed: assert property (p_clk_framed)
    else $error("clock outside a frame");

  property p_tail;
    $fell(serialEnable) |-> !serialClock;
  endproperty
  a_tail: assert property (p_tail)
    else $error("enable dropped with clock high");
endmodule

`default_nettype wire

//--- tb/tb_dual_wiper_serial_shift_port.sv
// bench: host and device face each other; a second device is driven by hand
// assumes the clock period of 50 ns and the link half period of 4 cycles
`timescale 1ns/1ps
`default_nettype none

module tb_dual_wiper_serial_shift_port
  import dwsp_pkg::*;
;
  logic        ref_clk;
  logic        rst;
  logic        start;
  logic        readBack;
  logic [16:0] txWord;
  logic        done;
  logic        busy;
  logic [16:0] rxWord;
  logic [7:0]  wZero, wOne, sWip, bZero, bOne;
  logic        sSel, hz, lz, ho, lo, wLoad, bSel, bLoad;
  logic [16:0] w, model, loaded;
  logic [31:0] seed;
  logic [16:0] corner [4] = '{17'h1ffff, 17'h00000, 17'h0ff00, 17'h100ff};
  int          errTotal, checks, cycles;

  dwsp_if lnk();
  dwsp_if lnk2();

  dwsp_host #(.DEVICES(1)) i_dwsp_host (.ref_clk(ref_clk), .rst(rst), .link(lnk.host),
    .start(start), .readBack(readBack), .txWord(txWord), .busy(busy), .done(done),
    .rxWord(rxWord));
  dwsp_device i_dwsp_device (.ref_clk(ref_clk), .rst(rst), .link(lnk.device),
    .wiperZero(wZero), .wiperOne(wOne), .stackSel(sSel), .stackedWiper(sWip),
    .highEndTerminalZero(hz), .lowEndTerminalZero(lz), .highEndTerminalOne(ho),
    .lowEndTerminalOne(lo), .wiperLoad(wLoad));
  // hand-driven end: lets the bench break the controller's side on purpose
  dwsp_device i_dwsp_device_2 (.ref_clk(ref_clk), .rst(rst), .link(lnk2.device),
    .wiperZero(bZero), .wiperOne(bOne), .stackSel(bSel), .stackedWiper(),
    .highEndTerminalZero(), .lowEndTerminalZero(), .highEndTerminalOne(),
    .lowEndTerminalOne(), .wiperLoad(bLoad));
  dwsp_checker i_dwsp_checker (.ref_clk(ref_clk), .rst(rst),
    .serialEnable(lnk.serialEnable), .serialClock(lnk.serialClock),
    .cascadeOut(lnk.cascadeOut), .wiperZero(wZero), .wiperOne(wOne), .stackSel(sSel),
    .stackedWiper(sWip), .highEndTerminalZero(hz), .lowEndTerminalZero(lz),
    .highEndTerminalOne(ho), .lowEndTerminalOne(lo), .wiperLoad(wLoad));

  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  always #25 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 12000) begin
      errTotal++;
      testDone();
    end
  end

  task automatic testDone();
    if (errTotal == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    logic [31:0] r;
    r = s;
    for (int i = 0; i < 17; i++) r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
    return r;
  endfunction

  // register positions to {stack, wiper one, wiper zero}, msb nearest stack
  function automatic logic [16:0] fields(input logic [16:0] m);
    logic [16:0] r;
    r[16] = m[0];
    for (int i = 1; i <= 16; i++) r[16 - i] = m[i];
    return r;
  endfunction

  task automatic waitLoad(input logic dev);
    int n;
    n = 0;
    while ((dev ? bLoad : wLoad) !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk(17'(n < 20), 17'h1);
  endtask

  task automatic hostRun(input logic [16:0] v, input logic rb);
    int n;
    txWord = v;
    readBack = rb;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    chk(17'({busy, lnk.serialEnable}), 17'h00003);
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk(17'({busy, lnk.serialEnable}), 17'h00000);
    waitLoad(1'b0);
  endtask

  task automatic checkMain(input logic [16:0] v);
    chk({sSel, wOne, wZero}, v);
    chk(17'(sWip), 17'(v[16] ? v[15:8] : v[7:0]));
    chk(17'({hz, lz, ho, lo}), 17'({v[7:0] == WIPER_HIGH_END, v[7:0] == WIPER_LOW_END,
      v[15:8] == WIPER_HIGH_END, v[15:8] == WIPER_LOW_END}));
  endtask

  task automatic bClock(input logic d);
    lnk2.hostData = d;
    tick(4);
    lnk2.serialClock = 1'b1;
    if (lnk2.serialEnable) model = {lnk2.dataLine, model[16:1]};
    tick(4);
    lnk2.serialClock = 1'b0;
    chk(17'(lnk2.cascadeOut), 17'(model[0]));
  endtask

  task automatic bFrame(input int n, input logic [16:0] v, input logic oe);
    lnk2.hostDataOe = oe;
    lnk2.serialEnable = 1'b1;
    tick(4);
    chk(17'(lnk2.cascadeOut), 17'(model[0]));
    for (int i = 0; i < n; i++) bClock(v[16 - (i % 17)]);
    chk({bSel, bOne, bZero}, loaded);
    tick(4);
    lnk2.serialEnable = 1'b0;
    lnk2.hostDataOe = 1'b0;
    waitLoad(1'b1);
    loaded = fields(model);
    chk({bSel, bOne, bZero}, loaded);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    start = 1'b0;
    readBack = 1'b0;
    txWord = 17'h00000;
    errTotal = 0;
    checks = 0;
    cycles = 0;
    seed = 32'h00000034;
    model = 17'h00000;
    loaded = 17'h00000;
    lnk2.serialEnable = 1'b0;
    lnk2.serialClock = 1'b0;
    lnk2.hostData = 1'b0;
    lnk2.hostDataOe = 1'b0;
    tick(2);
    rst = 1'b0;
    tick(2);
    chk({sSel, wOne, wZero}, 17'h00000);
    chk(17'({hz, lz, ho, lo}), 17'h00005);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      w = (i < 4) ? corner[i] : seed[16:0];
      hostRun(w, 1'b0);
      checkMain(w);
      hostRun(~w, 1'b1);
      chk(rxWord, w);
      checkMain(w);
    end
    bFrame(17, seed[16:0], 1'b1);
    seed = lfsr(seed);
    bFrame(34, seed[16:0], 1'b1);
    // stray clocks with enable low must change nothing
    for (int i = 0; i < 6; i++) bClock(seed[i]);
    chk({bSel, bOne, bZero}, loaded);
    seed = lfsr(seed);
    bFrame(9, seed[16:0], 1'b1);
    bFrame(17, 17'h00000, 1'b0);
    testDone();
  end
endmodule

`default_nettype wire
